// [common/tic_pkg.sv]
// Constants and types shared by the time interval counter block
package tic_pkg;
  // ----------------------------------------
  // Register indices, byte address is four times the index
  // ----------------------------------------
  localparam logic [7:0] IDX_CTRL     = 8'ha1;
  localparam logic [7:0] IDX_FRAC     = 8'ha2;
  localparam logic [7:0] IDX_SEC      = 8'ha3;
  localparam logic [7:0] IDX_MIN      = 8'ha4;
  localparam logic [7:0] IDX_HOUR     = 8'ha5;
  localparam logic [7:0] IDX_CMP      = 8'ha6;
  localparam logic [7:0] IDX_CNT      = 8'ha7;
  localparam logic [7:0] IDX_IRQ_STAT = 8'ha8;
  localparam logic [7:0] IDX_IRQ_MASK = 8'ha9;
  localparam int ADDR_W   = 10;
  localparam int ADDR_LSB = 2;
  localparam int DATA_W   = 32;
  // ----------------------------------------
  // Reset values, masks and count limits
  // ----------------------------------------
  localparam logic [7:0] CTRL_RESET    = 8'h00;
  localparam logic [7:0] CTRL_WMASK    = 8'h7b;
  localparam logic [7:0] CTRL_RMASK    = 8'h7f;
  localparam logic [7:0] CMP_RESET     = 8'h00;
  localparam logic [7:0] TIME_RESET    = 8'h00;
  localparam logic [7:0] CNT_RESET     = 8'h00;
  localparam logic [7:0] IRQ_RESET     = 8'h00;
  localparam logic [7:0] IRQ_MATCH     = 8'h01;
  localparam logic [7:0] FRAC_MAX      = 8'h7f;
  localparam logic [7:0] SEC_MAX       = 8'h3b;
  localparam logic [7:0] MIN_MAX       = 8'h3b;
  localparam logic [7:0] HOUR_MAX_24   = 8'h17;
  localparam logic [7:0] HOUR_MAX_FREE = 8'hff;
  localparam logic [7:0] CNT_STEP      = 8'h01;
  // ----------------------------------------
  // Timing: one fraction tick is 1/128 second
  // ----------------------------------------
  localparam longint FRAC_PERIOD_NS = 7812500;
  localparam longint CLK_PERIOD_NS  = 5;
  localparam int     FRAC_CYCLES    = int'(FRAC_PERIOD_NS / CLK_PERIOD_NS);
  // Interval timebase codes
  typedef enum logic [1:0] {
    TB_FRAC = 2'h0,
    TB_SEC  = 2'h1,
    TB_MIN  = 2'h2,
    TB_HOUR = 2'h3
  } timebase_e;
  // Control register layout
  typedef struct packed {
    logic      reserved;
    logic      hour_24_select;
    timebase_e timebase;
    logic      single_interval_mode;
    logic      interval_match_flag;
    logic      interval_count_enable;
    logic      time_clock_enable;
  } ctrl_s;
  // Time of day counters
  typedef struct packed {
    logic [7:0] hour;
    logic [7:0] minute;
    logic [7:0] second;
    logic [7:0] fraction;
  } time_s;
  // Wishbone classic request from the master
  typedef struct packed {
    logic              cyc;
    logic              stb;
    logic              we;
    logic [3:0]        sel;
    logic [ADDR_W-1:0] adr;
    logic [DATA_W-1:0] dat;
  } wb_req_s;
endpackage : tic_pkg

// [rtl/time_interval_counter_control.sv]
// Time interval counter with time of day counters and Wishbone registers
//
// The implementer's own choice: the Wishbone interface to the registers.
`timescale 1ns/100ps
module time_interval_counter_control #(
  parameter int TICK_CYCLES = tic_pkg::FRAC_CYCLES  // Clock cycles per 1/128 s
) (
  input  wire logic                       clock_in,     // Core clock, 200 MHz
  input  wire logic                       arst_n_in,    // Async reset, active low
  input  wire tic_pkg::wb_req_s           wb_req_in,    // Wishbone request
  output logic                            wb_ack_out,   // Wishbone acknowledge
  output logic [tic_pkg::DATA_W-1:0]      wb_dat_out,   // Wishbone read data
  input  wire logic                       power_down_in, // Device in power-down
  output logic                            irq_out,      // Interrupt, level
  output logic                            wake_out      // Wake from power-down
);
  import tic_pkg::*;

  // ----------------------------------------
  // Parameter check
  // ----------------------------------------
  // Divider needs a counter of at least one bit
  if (TICK_CYCLES < 2) begin : g_bad_tick
    $error("TICK_CYCLES must be at least 2");
  end
  // Register index must be exactly one register wide
  if (ADDR_W - ADDR_LSB != $bits(ctrl_s)) begin : g_bad_addr
    $error("Address width must leave a byte-wide register index");
  end

  localparam int TICK_W = $clog2(TICK_CYCLES);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);
  localparam logic [TICK_W-1:0] TICK_ZERO = '0;
  localparam logic [TICK_W-1:0] TICK_ONE  = TICK_W'(1);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  ctrl_s             ctrl_r;
  ctrl_s             ctrl_nxt;
  time_s             time_r;
  time_s             shadow_r;
  logic [7:0]        cmp_r;
  logic [7:0]        cnt_r;
  logic [7:0]        cnt_inc;
  logic [7:0]        irq_stat_r;
  logic [7:0]        irq_stat_nxt;
  logic [7:0]        irq_mask_r;
  logic [TICK_W-1:0] tick_cnt_r;
  logic              ack_r;
  logic [DATA_W-1:0] dat_r;
  logic              irq_r;
  logic              wake_r;
  logic [7:0]        rd_mux;
  logic [7:0]        idx;
  logic [7:0]        wdat;
  logic              wb_req;
  logic              wr;
  logic              tick;
  logic              frac_wrap;
  logic              sec_wrap;
  logic              min_wrap;
  logic [7:0]        hour_max;
  logic              step;
  logic              run;
  logic              match;
  ctrl_s             wdat_ctrl;
  logic              irq_pend;

  // ----------------------------------------
  // Wishbone slave
  // ----------------------------------------
  // Request decode, write lands on the edge that sees ack
  assign wb_req = wb_req_in.cyc & wb_req_in.stb;
  assign idx    = wb_req_in.adr[ADDR_W-1:ADDR_LSB];
  assign wdat   = wb_req_in.dat[7:0];
  assign wr     = wb_req & ack_r & wb_req_in.we & wb_req_in.sel[0];

  // Write data viewed as control fields
  assign wdat_ctrl = ctrl_s'(wdat);

  // Read multiplexer, unmapped and reserved bits read zero
  always_comb begin
    rd_mux = 8'h00;
    unique case (idx)
      IDX_CTRL:     rd_mux = ctrl_r & CTRL_RMASK;
      IDX_FRAC:     rd_mux = time_r.fraction;
      IDX_SEC:      rd_mux = time_r.second;
      IDX_MIN:      rd_mux = time_r.minute;
      IDX_HOUR:     rd_mux = time_r.hour;
      IDX_CMP:      rd_mux = cmp_r;
      IDX_CNT:      rd_mux = cnt_r;
      IDX_IRQ_STAT: rd_mux = irq_stat_r;
      IDX_IRQ_MASK: rd_mux = irq_mask_r;
      default:      rd_mux = 8'h00;
    endcase
  end

  // Ack one cycle after the request, dropped the next cycle
  // Gated by itself so a held request is acked every other cycle, never two in a row
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= wb_req & ~ack_r;
    end
  end

  // Read data captured with the ack
  // Taken at the request edge so it stands with the ack
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      dat_r <= '0;
    end else if (wb_req & ~ack_r) begin
      dat_r <= {24'h000000, rd_mux};
    end
  end

  // ----------------------------------------
  // Fraction tick, stands in for the crystal
  // ----------------------------------------
  // Divider held at zero while the time clock is off
  // A restart then waits one full tick period
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      tick_cnt_r <= TICK_ZERO;
    end else if (!ctrl_r.time_clock_enable) begin
      tick_cnt_r <= TICK_ZERO;
    end else if (tick_cnt_r == TICK_LAST) begin
      tick_cnt_r <= TICK_ZERO;
    end else begin
      tick_cnt_r <= tick_cnt_r + TICK_ONE;
    end
  end

  // Runs independent of power-down
  // Power-down gates the core only, never this tick
  assign tick = ctrl_r.time_clock_enable & (tick_cnt_r == TICK_LAST);

  // ----------------------------------------
  // Time of day counters
  // ----------------------------------------
  // Carry chain between the time units
  // Compared with >= so out of range values still wrap
  assign frac_wrap = tick & (time_r.fraction >= FRAC_MAX);
  assign sec_wrap  = frac_wrap & (time_r.second >= SEC_MAX);
  assign min_wrap  = sec_wrap & (time_r.minute >= MIN_MAX);
  assign hour_max  = ctrl_r.hour_24_select ? HOUR_MAX_24 : HOUR_MAX_FREE;

  // Software copy of the time, loaded by register writes
  // Kept apart so a stop restores what software wrote
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      shadow_r <= {4{TIME_RESET}};
    end else if (wr) begin
      // Writes with the clock running are unsupported
      if (idx == IDX_FRAC) shadow_r.fraction <= wdat;
      if (idx == IDX_SEC)  shadow_r.second   <= wdat;
      if (idx == IDX_MIN)  shadow_r.minute   <= wdat;
      if (idx == IDX_HOUR) shadow_r.hour     <= wdat;
    end
  end

  // Counters follow the copy while stopped, else advance
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      time_r <= {4{TIME_RESET}};
    end else if (!ctrl_r.time_clock_enable) begin
      time_r <= shadow_r;
    end else if (tick) begin
      if (frac_wrap) begin
        time_r.fraction <= TIME_RESET;
      end else begin
        time_r.fraction <= time_r.fraction + CNT_STEP;
      end
      if (sec_wrap) begin
        time_r.second <= TIME_RESET;
      end else if (frac_wrap) begin
        time_r.second <= time_r.second + CNT_STEP;
      end
      if (min_wrap) begin
        time_r.minute <= TIME_RESET;
      end else if (sec_wrap) begin
        time_r.minute <= time_r.minute + CNT_STEP;
      end
      if (min_wrap) begin
        if (time_r.hour >= hour_max) begin
          time_r.hour <= TIME_RESET;
        end else begin
          time_r.hour <= time_r.hour + CNT_STEP;
        end
      end
    end
  end

  // ----------------------------------------
  // Interval counter
  // ----------------------------------------
  // Advance source chosen by the timebase field
  always_comb begin
    step = 1'b0;
    unique case (ctrl_r.timebase)
      TB_FRAC: step = tick;
      TB_SEC:  step = frac_wrap;
      TB_MIN:  step = sec_wrap;
      TB_HOUR: step = min_wrap;
    endcase
  end

  // Match on the step that would reach the compare value
  assign run     = ctrl_r.time_clock_enable & ctrl_r.interval_count_enable;
  assign cnt_inc = cnt_r + CNT_STEP;
  assign match   = run & step & (cnt_inc == cmp_r);

  // Count, clear on match, restart from zero when disabled
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cnt_r <= CNT_RESET;
    end else if (!ctrl_r.interval_count_enable) begin
      cnt_r <= CNT_RESET;
    end else if (match) begin
      cnt_r <= CNT_RESET;
    end else if (run & step) begin
      cnt_r <= cnt_inc;
    end
  end

  // ----------------------------------------
  // Control and compare registers
  // ----------------------------------------
  // Next control value, the match flag set beats a clear
  // Hardware clear of the enable also beats a same cycle write
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (wr && idx == IDX_CTRL) begin
      ctrl_nxt = ctrl_s'((wdat & CTRL_WMASK) | (ctrl_r & ~CTRL_WMASK));
      // Flag clears only by software writing zero
      ctrl_nxt.interval_match_flag = ctrl_r.interval_match_flag
                                     & wdat_ctrl.interval_match_flag;
    end
    if (match) begin
      ctrl_nxt.interval_match_flag = 1'b1;
      if (ctrl_r.single_interval_mode) begin
        ctrl_nxt.interval_count_enable = 1'b0;
      end
    end
  end

  // Control register update
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ctrl_r <= ctrl_s'(CTRL_RESET);
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // Interval compare value
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cmp_r <= CMP_RESET;
    end else if (wr && idx == IDX_CMP) begin
      cmp_r <= wdat;
    end
  end

  // ----------------------------------------
  // Interrupt status and mask
  // ----------------------------------------
  // Sticky status, write one to clear, event wins
  always_comb begin
    irq_stat_nxt = irq_stat_r;
    if (wr && idx == IDX_IRQ_STAT) begin
      irq_stat_nxt = irq_stat_r & ~(wdat & IRQ_MATCH);
    end
    if (match) begin
      irq_stat_nxt = irq_stat_nxt | IRQ_MATCH;
    end
  end

  // Status register
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      irq_stat_r <= IRQ_RESET;
    end else begin
      irq_stat_r <= irq_stat_nxt;
    end
  end

  // Mask register, a one enables the event
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      irq_mask_r <= IRQ_RESET;
    end else if (wr && idx == IDX_IRQ_MASK) begin
      irq_mask_r <= wdat & IRQ_MATCH;
    end
  end

  // Pending while an unmasked status bit is set
  assign irq_pend = |(irq_stat_r & irq_mask_r);

  // Level interrupt output
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= irq_pend;
    end
  end

  // Wake request, only while the device sleeps
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wake_r <= 1'b0;
    end else begin
      wake_r <= power_down_in & irq_pend;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Every output is driven by a register
  assign wb_ack_out = ack_r;
  assign wb_dat_out = dat_r;
  assign irq_out    = irq_r;
  assign wake_out   = wake_r;
endmodule : time_interval_counter_control

// [verification/time_interval_counter_control_chk.sv]
// Bus and interrupt assertions for the time interval counter control block
`timescale 1ns/100ps
module time_interval_counter_control_chk #(
  parameter int TICK_CYCLES = 4  // Clock cycles per fraction tick
) (
  input  wire logic                  clock_in,      // Core clock
  input  wire logic                  arst_n_in,     // Async reset, active low
  input  wire tic_pkg::wb_req_s      wb_req_in,     // Wishbone request
  input  wire logic                  wb_ack_out,    // Wishbone acknowledge
  input  wire logic [31:0]           wb_dat_out,    // Wishbone read data
  input  wire logic                  power_down_in, // Device in power-down
  input  wire logic                  irq_out,       // Interrupt level
  input  wire logic                  wake_out       // Wake request
);
  import tic_pkg::*;
  // Request and read acknowledge shorthands
  logic req;
  logic rd_ack;
  assign req    = wb_req_in.cyc & wb_req_in.stb;
  assign rd_ack = wb_ack_out & ~wb_req_in.we;
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!arst_n_in);
  chk_ack_one_cycle: assert property (req && !wb_ack_out |=> wb_ack_out)
    else $error("ack not one cycle after request");
  chk_ack_single_pulse: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack longer than one cycle");
  chk_ack_needs_req: assert property (wb_ack_out |-> $past(req))
    else $error("ack without request");
  chk_read_upper_zero: assert property (rd_ack |-> wb_dat_out[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  chk_ctrl_rsvd_zero: assert property (
    rd_ack && wb_req_in.adr == {IDX_CTRL, 2'b00} |-> !wb_dat_out[7])
    else $error("reserved control bit reads one");
  chk_irq_sticky: assert property (
    irq_out && !wb_req_in.cyc && !$past(wb_req_in.cyc) |=> irq_out)
    else $error("interrupt dropped without software write");
  chk_wake_power_down: assert property (wake_out |-> $past(power_down_in))
    else $error("wake outside power-down");
  chk_wake_with_irq: assert property (wake_out |-> irq_out)
    else $error("wake without interrupt");
endmodule : time_interval_counter_control_chk
bind time_interval_counter_control time_interval_counter_control_chk #(
  .TICK_CYCLES(TICK_CYCLES)
) u_chk (
  .clock_in(clock_in), .arst_n_in(arst_n_in), .wb_req_in(wb_req_in),
  .wb_ack_out(wb_ack_out), .wb_dat_out(wb_dat_out), .power_down_in(power_down_in),
  .irq_out(irq_out), .wake_out(wake_out)
);

// [verification/test_time_interval_counter_control.sv]
// Self-checking bench for the time interval counter control block
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin n_fail++; \
  $display("mismatch %s exp %h got %h", nm, exp, got); end end
module test_time_interval_counter_control;
  import tic_pkg::*;
  logic              clock_in, arst_n_in, power_down_in, wb_ack_out, irq_out, wake_out;
  logic [DATA_W-1:0] wb_dat_out;
  logic [31:0]       rd;
  wb_req_s           wb_req_in;
  int                n_fail, compares, cyc_n, k;
  time_interval_counter_control #(.TICK_CYCLES(4)) dut (
    .clock_in(clock_in), .arst_n_in(arst_n_in), .wb_req_in(wb_req_in),
    .wb_ack_out(wb_ack_out), .wb_dat_out(wb_dat_out), .power_down_in(power_down_in),
    .irq_out(irq_out), .wake_out(wake_out));
  // Clock and hang guard
  initial begin
    clock_in = 1'b0;
    forever #2.5 clock_in = ~clock_in;
  end
  always @(posedge clock_in) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      n_fail++;
      final_report();
    end
  end
  // ----------------------------------------
  // Bus tasks
  // ----------------------------------------
  task automatic final_report();
    if (n_fail == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report
  task automatic bus(input logic we, input logic [7:0] idx, input logic [7:0] wd,
                     input logic [3:0] sel);
    int n;
    @(posedge clock_in);
    wb_req_in <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: sel, adr: {idx, 2'b00},
                   dat: {24'h0, wd}};
    n = 0;
    do begin
      @(posedge clock_in);
      n++;
    end while (wb_ack_out !== 1'b1 && n < 20);
    rd = wb_dat_out;
    wb_req_in.cyc <= 1'b0;
    wb_req_in.stb <= 1'b0;
    if (n >= 20) n_fail++;
  endtask : bus
  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    bus(1'b1, idx, v, 4'hf);
  endtask : wr
  task automatic chk_rd(input string nm, input logic [7:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00, 4'hf);
    `CHK(nm, {24'h0, exp}, rd)
  endtask : chk_rd
  task automatic wait_irq(input logic v, input int lim);
    int n;
    n = 0;
    while (irq_out !== v && n < lim) begin
      @(posedge clock_in);
      n++;
    end
    `CHK("irq_out", v, irq_out)
  endtask : wait_irq
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    arst_n_in = 1'b0;
    power_down_in = 1'b0;
    wb_req_in = '0;
    repeat (8) @(posedge clock_in);
    arst_n_in <= 1'b1;
    chk_rd("ctrl", IDX_CTRL, CTRL_RESET);
    chk_rd("cmp", IDX_CMP, CMP_RESET);
    wr(IDX_CTRL, 8'hf0);
    chk_rd("ctrl", IDX_CTRL, 8'h70);
    wr(IDX_CTRL, 8'h00);
    bus(1'b1, IDX_CMP, 8'h5a, 4'he);
    chk_rd("cmp", IDX_CMP, CMP_RESET);
    wr(IDX_CMP, 8'hff);
    chk_rd("cmp", IDX_CMP, 8'hff);
    // Rollover in 24-hour mode, free mode past 23 and free mode at 255
    for (int m = 0; m < 3; m++) begin
      wr(IDX_FRAC, 8'h7e);
      wr(IDX_SEC, SEC_MAX);
      wr(IDX_MIN, MIN_MAX);
      wr(IDX_HOUR, (m == 2) ? HOUR_MAX_FREE : HOUR_MAX_24);
      wr(IDX_CTRL, (m == 0) ? 8'h41 : 8'h01);
      k = 0;
      do begin
        bus(1'b0, IDX_FRAC, 8'h00, 4'hf);
        k++;
      end while (rd[7:0] !== 8'h00 && k < 40);
      `CHK("frac", 8'h00, rd[7:0])
      chk_rd("sec", IDX_SEC, 8'h00);
      chk_rd("min", IDX_MIN, 8'h00);
      chk_rd("hour", IDX_HOUR, (m == 1) ? 8'h18 : 8'h00);
      wr(IDX_CTRL, 8'h00);
      chk_rd("frac", IDX_FRAC, 8'h7e);
    end
    // Single interval, then auto reload
    wr(IDX_CMP, 8'h03);
    wr(IDX_IRQ_MASK, IRQ_MATCH);
    for (int m = 0; m < 2; m++) begin
      wr(IDX_CTRL, m ? 8'h03 : 8'h0b);
      wait_irq(1'b1, 100);
      chk_rd("ctrl", IDX_CTRL, m ? 8'h07 : 8'h0d);
      chk_rd("stat", IDX_IRQ_STAT, IRQ_MATCH);
      if (m == 0) chk_rd("cnt", IDX_CNT, CNT_RESET);
      power_down_in <= 1'b1;
      repeat (3) @(posedge clock_in);
      `CHK("wake_out", 1'b1, wake_out)
      power_down_in <= 1'b0;
      wr(IDX_IRQ_STAT, IRQ_MATCH);
      wait_irq(1'b0, 10);
      if (m) begin
        wait_irq(1'b1, 100);
      end else begin
        repeat (60) @(posedge clock_in);
        `CHK("irq_out", 1'b0, irq_out)
      end
      wr(IDX_CTRL, 8'h00);
      chk_rd("ctrl", IDX_CTRL, 8'h00);
      wr(IDX_IRQ_STAT, IRQ_MATCH);
    end
    // Masked match leaves the line low but sets status
    wr(IDX_IRQ_MASK, 8'h00);
    wr(IDX_CTRL, 8'h03);
    repeat (40) @(posedge clock_in);
    `CHK("irq_out", 1'b0, irq_out)
    chk_rd("stat", IDX_IRQ_STAT, IRQ_MATCH);
    // Seconds timebase: one step per 128 fraction ticks
    wr(IDX_CTRL, 8'h00);
    wr(IDX_FRAC, 8'h00);
    wr(IDX_SEC, 8'h00);
    wr(IDX_IRQ_STAT, IRQ_MATCH);
    wr(IDX_IRQ_MASK, IRQ_MATCH);
    wr(IDX_CMP, 8'h01);
    wr(IDX_CTRL, 8'h13);
    repeat (400) @(posedge clock_in);
    `CHK("irq_out", 1'b0, irq_out)
    wait_irq(1'b1, 300);
    // Minute and hour timebases: the carry below must not step, their own must
    for (int tb = 2; tb < 4; tb++) begin
      wr(IDX_CTRL, 8'h00);
      wr(IDX_IRQ_STAT, IRQ_MATCH);
      wr(IDX_SEC, (tb == 2) ? 8'h3a : SEC_MAX);
      wr(IDX_MIN, (tb == 2) ? 8'h00 : 8'h3a);
      wr(IDX_CTRL, (tb == 2) ? 8'h23 : 8'h33);
      repeat (600) @(posedge clock_in);
      `CHK("irq_out", 1'b0, irq_out)
      wr(IDX_CTRL, (tb == 2) ? 8'h22 : 8'h32);
      wr(IDX_SEC, SEC_MAX);
      wr(IDX_MIN, MIN_MAX);
      wr(IDX_CTRL, (tb == 2) ? 8'h23 : 8'h33);
      wait_irq(1'b1, 600);
    end
    // Mid-run reset returns the registers to zero
    wr(IDX_CMP, 8'h5a);
    arst_n_in <= 1'b0;
    repeat (2) @(posedge clock_in);
    arst_n_in <= 1'b1;
    `CHK("irq_out", 1'b0, irq_out)
    chk_rd("ctrl", IDX_CTRL, CTRL_RESET);
    chk_rd("cmp", IDX_CMP, CMP_RESET);
    chk_rd("stat", IDX_IRQ_STAT, IRQ_RESET);
    final_report();
  end
endmodule : test_time_interval_counter_control
